//--- src/mfpc_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - sdr write: one word per clk rise with enable, select low, not full
// - ddr write: rise and following fall word stored when rise qualifies
// - write enable and select are looked at on rising edges only
// - select high at a rise blocks that rise and its fall word
// - words stored in order; write side independent of reads
// - static rate pins pick ddr when high; never toggled by the user
// - sdr read: one word per read rise with enable, select low, data
// - ddr read: words on both read edges; controls looked at on rise
// - enable or select high holds the read pointer, except for the fall-through first word
// - flag timing select low: empty flags tracked on clk, no read clock
// - standard mode: empty flag low once drained, reads blocked meanwhile
// - standard mode, flag timing select high: empty flag rises a few read edges after a write into empty
// - fall-through: ready flag goes high once all words are read out
// - select low enables output next read rise; high disables and blocks
// - during reset only the output enable governs the output drive
// - flags update whatever the read select does
// - fall-through: first word loads output register without select
// - one instance per port set; unused sets are tied off outside
// - first fall-through word may lag one read cycle on clock skew
module mfpc_port_ctrl
    import mfpc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       rclk,
    input  wire logic [mfpc_pkg::DATA_W-1:0] data_in,
    input  wire logic                       write_enable_n,
    input  wire logic                       write_select_n,
    input  wire logic                       write_double_rate_pin,
    input  wire logic                       read_enable_n,
    input  wire logic                       read_select_n,
    input  wire logic                       read_double_rate_pin,
    input  wire logic                       output_enable_n,
    input  wire logic                       fall_through_mode,
    input  wire logic                       flag_timing_select,
    output logic [mfpc_pkg::DATA_W-1:0]     data_out,
    output logic                            data_out_oe,
    output logic                            empty_flag_n,
    output logic                            output_ready_n,
    output logic                            almost_empty_flag_n,
    output logic                            full_flag_n,
    output logic                            almost_full_flag_n
);
    import mfpc_pkg::*;

    // ==================================================================
    // write domain state
    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        logic [PTR_W-1:0]             wptr;
        logic                         fall_pend;
        logic [PTR_W-1:0]             rq1;
        logic [PTR_W-1:0]             rq2;
        logic [PTR_W-1:0]             rq3;
        logic [PTR_W-1:0]             rbin;
        logic                         full_n;
        logic                         af_n;
        logic                         empty_async_n;
        logic                         ae_async_n;
    } mfpc_wst_t;

    // read domain state
    typedef struct packed {
        logic [PTR_W-1:0]  wq1;
        logic [PTR_W-1:0]  wq2;
        logic [PTR_W-1:0]  wq3;
        logic [PTR_W-1:0]  wbin;
        logic [PTR_W-1:0]  rptr;
        logic [DATA_W-1:0] q_word;
        logic [DATA_W-1:0] fall_word;
        logic              fall_pend;
        logic              ptog;
        logic              out_en;
        logic              or_valid;
        logic              empty_n;
        logic              ae_n;
        logic              fall_mode;
        logic              cfg_done;
    } mfpc_rst_t;

    mfpc_wst_t         st_w;
    mfpc_wst_t         next_st_w;
    mfpc_rst_t         st_r;
    mfpc_rst_t         next_st_r;
    logic [DATA_W-1:0] wfall_data;
    logic              ntog;
    logic [PTR_W-1:0]  free_w;
    logic [PTR_W-1:0]  avail_r;
    logic              rd_req;

    // ==================================================================
    // write port
    // falling-edge data capture for the second word of a ddr pair
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wfall_data <= WORD_RST;
        end else begin
            wfall_data <= data_in;
        end
    end

    // next write state
    always_comb begin
        logic [PTR_W-1:0] wp;
        logic [PTR_W-1:0] rb;
        logic             qual;
        wp        = st_w.wptr;
        rb        = st_w.rbin;
        qual      = 1'b0;
        next_st_w = st_w;
        // pending fall word lands first, keeping order
        if (st_w.fall_pend) begin
            next_st_w.mem[wp[ADDR_W-1:0]] = wfall_data;
            wp = wp + 5'h01;
        end
        next_st_w.fall_pend = 1'b0;
        // controls sampled only here, on the rise
        qual = !write_enable_n && !write_select_n;
        free_w = PTR_W'(DEPTH) - (st_w.wptr - rb) - {4'h0, st_w.fall_pend};
        if (qual && write_double_rate_pin && free_w >= 5'h02) begin
            next_st_w.mem[wp[ADDR_W-1:0]] = data_in;
            next_st_w.fall_pend           = 1'b1;
            wp = wp + 5'h01;
        end else if (qual && !write_double_rate_pin && free_w != 5'h00) begin
            next_st_w.mem[wp[ADDR_W-1:0]] = data_in;
            wp = wp + 5'h01;
        end // else full: dropped
        next_st_w.wptr = wp;
        // read pointer crossing, accepted once stages two and three agree
        next_st_w.rq1 = mfpc_bin2gray(st_r.rptr);
        next_st_w.rq2 = st_w.rq1;
        next_st_w.rq3 = st_w.rq2;
        if (st_w.rq2 == st_w.rq3) begin
            rb = mfpc_gray2bin(st_w.rq3);
        end
        next_st_w.rbin = rb;
        next_st_w.full_n = (wp - rb) <= PTR_W'(DEPTH - 2);
        next_st_w.af_n = (wp - rb) < PTR_W'(DEPTH) - AF_OFFSET;
        // free-running empty view for the asynchronous flag timing
        next_st_w.empty_async_n = (wp != rb);
        next_st_w.ae_async_n = (wp - rb) > AE_OFFSET;
    end

    // write registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_w      <= '0;
            st_w.full_n <= 1'b1;
            st_w.af_n <= 1'b1;
        end else begin
            st_w <= next_st_w;
        end
    end

    // ==================================================================
    // read port
    assign rd_req  = !read_enable_n && !read_select_n;
    assign avail_r = st_r.wbin - st_r.rptr;

    // falling-edge half of the ddr output toggle pair
    always_ff @(negedge rclk or negedge rst_n) begin
        if (!rst_n) begin
            ntog <= 1'b0;
        end else begin
            ntog <= st_r.fall_pend ? ~st_r.ptog : st_r.ptog;
        end
    end

    // next read state
    always_comb begin
        logic [PTR_W-1:0] rp;
        logic [PTR_W-1:0] wb;
        logic             ddr;
        logic             fw;
        rp        = st_r.rptr;
        wb        = st_r.wbin;
        ddr       = read_double_rate_pin;
        fw        = st_r.cfg_done ? st_r.fall_mode : fall_through_mode;
        next_st_r = st_r;
        next_st_r.cfg_done = 1'b1;
        next_st_r.fall_mode = fw;
        next_st_r.ptog     = ntog;
        next_st_r.out_en   = !read_select_n;
        // a shown fall word stays as the held output word
        if (st_r.fall_pend) begin
            next_st_r.q_word = st_r.fall_word;
        end
        next_st_r.fall_pend = 1'b0;
        if (!fw) begin
            // standard mode: reads only while the empty flag is high
            if (rd_req && st_r.empty_n && (ddr ? avail_r >= 5'h02 : 1'b1)) begin
                next_st_r.q_word = st_w.mem[rp[ADDR_W-1:0]];
                if (ddr) begin
                    next_st_r.fall_word = st_w.mem[ADDR_W'(rp + 5'h01)];
                    next_st_r.fall_pend = 1'b1;
                end
                rp = rp + (ddr ? 5'h02 : 5'h01);
            end
        end else if (!st_r.or_valid) begin
            // first word falls through without any select
            if (avail_r != 5'h00) begin
                next_st_r.q_word   = st_w.mem[rp[ADDR_W-1:0]];
                next_st_r.or_valid = 1'b1;
                rp = rp + 5'h01;
            end
        end else if (rd_req) begin
            if (ddr && avail_r >= 5'h02) begin
                next_st_r.q_word    = st_w.mem[rp[ADDR_W-1:0]];
                next_st_r.fall_word = st_w.mem[ADDR_W'(rp + 5'h01)];
                next_st_r.fall_pend = 1'b1;
                rp = rp + 5'h02;
            end else if (avail_r != 5'h00) begin
                next_st_r.q_word = st_w.mem[rp[ADDR_W-1:0]];
                rp = rp + 5'h01;
            end else begin
                next_st_r.or_valid = 1'b0;
            end
        end
        next_st_r.rptr = rp;
        // write pointer crossing, accepted once stages two and three agree
        next_st_r.wq1 = mfpc_bin2gray(st_w.wptr);
        next_st_r.wq2 = st_r.wq1;
        next_st_r.wq3 = st_r.wq2;
        if (st_r.wq2 == st_r.wq3) begin
            wb = mfpc_gray2bin(st_r.wq3);
        end
        next_st_r.wbin = wb;
        // flags follow pointers only, never the select
        next_st_r.empty_n = (wb != rp);
        next_st_r.ae_n = (wb - rp) > AE_OFFSET;
    end

    // read registers
    always_ff @(posedge rclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= next_st_r;
        end
    end

    // ==================================================================
    // outputs
    assign data_out = (st_r.ptog ^ ntog) ? st_r.fall_word : st_r.q_word;
    // reset leaves only the output enable in control
    assign data_out_oe = rst_n ? (st_r.out_en && !output_enable_n) : !output_enable_n;
    // asynchronous flag timing uses the clk-tracked view
    assign empty_flag_n = st_r.fall_mode ? 1'b1
                        : (flag_timing_select ? st_r.empty_n : st_w.empty_async_n);
    assign almost_empty_flag_n = flag_timing_select ? st_r.ae_n : st_w.ae_async_n;
    assign output_ready_n      = !(st_r.fall_mode && st_r.or_valid);
    assign full_flag_n         = st_w.full_n;
    assign almost_full_flag_n  = st_w.af_n;

    // ==================================================================
    // checks, read domain
    property p_hold_when_idle;
        @(posedge rclk) disable iff (!rst_n)
        (read_select_n && st_r.or_valid) |=> $stable(st_r.rptr);
    endproperty
    a_hold_when_idle: assert property (p_hold_when_idle)
        else $error("read pointer moved while select high");

    property p_out_en_follows_select;
        @(posedge rclk) disable iff (!rst_n)
        read_select_n |=> !st_r.out_en ##0 !data_out_oe;
    endproperty
    a_out_en_follows_select: assert property (p_out_en_follows_select)
        else $error("output bus driven after select went high");

    property p_no_read_when_empty;
        @(posedge rclk) disable iff (!rst_n)
        (!st_r.fall_mode && st_r.cfg_done && !st_r.empty_n) |=> $stable(st_r.rptr);
    endproperty
    a_no_read_when_empty: assert property (p_no_read_when_empty)
        else $error("read taken while empty flag low");

    property p_ddr_read_pair;
        @(posedge rclk) disable iff (!rst_n)
        (!st_r.fall_mode && st_r.cfg_done && st_r.empty_n && rd_req && read_double_rate_pin
         && avail_r >= 5'h02) |=> (st_r.rptr == $past(st_r.rptr) + 5'h02) && st_r.fall_pend;
    endproperty
    a_ddr_read_pair: assert property (p_ddr_read_pair)
        else $error("ddr read did not take two words");

    property p_ready_flag;
        @(posedge rclk) disable iff (!rst_n)
        (st_r.fall_mode && st_r.or_valid && rd_req && avail_r == 5'h00)
        |=> output_ready_n;
    endproperty
    a_ready_flag: assert property (p_ready_flag)
        else $error("ready flag not raised after last word");

    // checks, write domain
    property p_full_drop;
        @(posedge clk) disable iff (!rst_n)
        (!st_w.fall_pend && free_w == 5'h00) |=> $stable(st_w.wptr);
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("write pointer moved while full");

    property p_sdr_write;
        @(posedge clk) disable iff (!rst_n)
        (!st_w.fall_pend && !write_enable_n && !write_select_n && !write_double_rate_pin
         && free_w != 5'h00) |=> st_w.wptr == $past(st_w.wptr) + 5'h01;
    endproperty
    a_sdr_write: assert property (p_sdr_write)
        else $error("sdr write not stored");

    property p_select_blocks;
        @(posedge clk) disable iff (!rst_n)
        (write_select_n && !st_w.fall_pend) |=> $stable(st_w.wptr) ##1 !$past(st_w.fall_pend);
    endproperty
    a_select_blocks: assert property (p_select_blocks)
        else $error("write taken with select high");

    property p_ddr_write;
        @(posedge clk) disable iff (!rst_n)
        (!write_enable_n && !write_select_n && write_double_rate_pin && free_w >= 5'h02)
        |=> st_w.fall_pend ##1 !$past(st_w.fall_pend) || st_w.wptr != $past(st_w.wptr);
    endproperty
    a_ddr_write: assert property (p_ddr_write)
        else $error("ddr fall word not stored");

endmodule // mfpc_port_ctrl
`default_nettype wire

//--- src/mfpc_pkg.sv
`default_nettype none
package mfpc_pkg;
    // ==================================================================
    // geometry
    localparam int DATA_W     = 10;
    localparam int ADDR_W     = 4;
    localparam int PTR_W      = ADDR_W + 1;
    localparam int DEPTH      = 1 << ADDR_W;
    // ==================================================================
    // programmable flag distances (words)
    localparam logic [PTR_W-1:0] AE_OFFSET = 5'h02;
    localparam logic [PTR_W-1:0] AF_OFFSET = 5'h02;
    // ==================================================================
    // reset values
    localparam logic [PTR_W-1:0]  PTR_RST  = 5'h00;
    localparam logic [DATA_W-1:0] WORD_RST = 10'h000;
    // ==================================================================
    // timing counts (read clock edges)
    localparam int EF_RISE_CYC   = 2;
    localparam int SYNC_STAGES   = 3;
    // ==================================================================
    // pointer helpers
    function automatic logic [PTR_W-1:0] mfpc_bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction
    function automatic logic [PTR_W-1:0] mfpc_gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction
endpackage
`default_nettype wire

//--- tb/mfpc_reader.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// reader model: read clock and read controls
module mfpc_reader (
    input  wire logic run,
    input  wire logic rd,
    input  wire logic sel,
    output logic      rclk,
    output logic      read_enable_n,
    output logic      read_select_n
);
    // 80 ns read clock, halted while run is low
    // phase stays 7 ns off the 10 ns grid, so edges never meet clk edges
    initial begin
        rclk = 1'h0;
        #7;
        forever begin
            if (run) #40 rclk = ~rclk;
            else #10;
        end
    end
    // controls idle high until asked for
    initial begin
        read_enable_n = 1'h1;
        read_select_n = 1'h1;
    end
    // controls move on the fall, clear of the sampling rise
    always @(negedge rclk) begin
        read_enable_n <= ~rd;
        read_select_n <= ~sel;
    end
endmodule // mfpc_reader
`default_nettype wire

//--- tb/mfpc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mfpc_tb_top;
    import mfpc_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic              clk = 1'h0;
    logic              rst_n = 1'h0;
    logic [DATA_W-1:0] data_in = 10'h000;
    logic [DATA_W-1:0] a, b, data_out;
    logic              wen_n = 1'h1, wsel_n = 1'h1, wrate = 1'h0, rrate = 1'h0, ftm = 1'h0;
    logic              oe_n = 1'h0, ftsel = 1'h1, run = 1'h1, rd = 1'h0, sel = 1'h0;
    logic              mon = 1'h0, rclk, ren_n, rsel_n;
    logic              oe, empty_n, or_n, ae_n, full_n, af_n;
    logic [DATA_W-1:0] q[$];
    int                failures = 0, n_checks = 0, seed = 55008, k;

    always #10 clk = ~clk;

    mfpc_port_ctrl mfpc_port_ctrl_i (
        .clk(clk), .rst_n(rst_n), .rclk(rclk), .data_in(data_in),
        .write_enable_n(wen_n), .write_select_n(wsel_n),
        .write_double_rate_pin(wrate), .read_enable_n(ren_n),
        .read_select_n(rsel_n), .read_double_rate_pin(rrate),
        .output_enable_n(oe_n), .fall_through_mode(ftm),
        .flag_timing_select(ftsel), .data_out(data_out), .data_out_oe(oe),
        .empty_flag_n(empty_n), .output_ready_n(or_n),
        .almost_empty_flag_n(ae_n), .full_flag_n(full_n),
        .almost_full_flag_n(af_n)
    );

    mfpc_reader mfpc_reader_i (
        .run(run), .rd(rd), .sel(sel), .rclk(rclk),
        .read_enable_n(ren_n), .read_select_n(rsel_n)
    );

    // ==========================================
    // compare and close
    task automatic check(input logic [DATA_W-1:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================
    // reset with static mode pins, checking reset outputs
    task automatic restart(input logic f, w, p);
        @(negedge clk);
        mon = 1'h0;
        rst_n = 1'h0;
        ftm = f;
        wrate = w;
        rrate = w;
        ftsel = p;
        run = 1'h1;
        rd = 1'h0;
        sel = 1'h0;
        q.delete();
        oe_n = 1'h1;
        #1 check(oe, 1'h0);
        oe_n = 1'h0;
        #1 check(oe, 1'h1);
        check({empty_n, or_n, full_n, af_n, ae_n}, 5'h0e);
        check(data_out, 10'h000);
        repeat (4) @(negedge clk);
        rst_n = 1'h1;
        repeat (8) @(negedge clk);
        mon = 1'h1;
    endtask

    // n write cycles; notes every word that must be kept
    task automatic wr(input logic en, cs, input int n);
        repeat (n) begin
            @(negedge clk);
            a = 10'($random(seed));
            b = 10'($random(seed));
            #5;
            data_in = a;
            wen_n = ~en;
            wsel_n = ~cs;
            if (en && cs && q.size() + wrate < DEPTH) begin
                q.push_back(a);
                if (wrate) q.push_back(b);
            end
            @(posedge clk);
            #5;
            data_in = b;
            wen_n = 1'h1;
        end
    endtask

    // read until every noted word is seen
    task automatic drain;
        // let the write pointer settle in the read domain first
        repeat (6) @(posedge rclk);
        rd = 1'h1;
        sel = 1'h1;
        for (k = 0; k < 400 && q.size() > 0; k++) @(posedge rclk);
        rd = 1'h0;
        repeat (4) @(posedge rclk);
        check(10'(q.size()), 10'h000);
        check(empty_n, 1'h0);
        $display("test done at %0t", $time);
    endtask

    // read monitor: each taken read pops the oldest note
    always @(posedge rclk) begin
        logic take, s;
        take = mon && !ftm && !ren_n && !rsel_n && empty_n;
        s = mon && rst_n && !rsel_n;
        #2;
        if (take) check(data_out, q.pop_front());
        if (mon) check(oe, s);
        // double rate: second word of the pair shows after the fall
        if (take && rrate) begin
            @(negedge rclk) #2;
            check(data_out, q.pop_front());
        end
    end

    // ==========================================
    // main sequence
    initial begin
        // first word while deselected: flag rises, bus stays off
        restart(1'h0, 1'h0, 1'h1);
        wr(1'h1, 1'h1, 1);
        for (k = 0; k < 8 && empty_n !== 1'h1; k++) @(posedge rclk) #1;
        check(10'(k >= 2 && k <= 4), 10'h001);
        check(oe, 1'h0);
        // mixed enables, then order of read back
        wr(1'h1, 1'h1, 5);
        wr(1'h0, 1'h1, 2);
        wr(1'h1, 1'h0, 2);
        drain();
        // overfill, extra words dropped
        wr(1'h1, 1'h1, 20);
        check({full_n, af_n}, 2'h0);
        drain();
        // async flags with the read clock halted
        restart(1'h0, 1'h0, 1'h0);
        run = 1'h0;
        wr(1'h1, 1'h1, 1);
        repeat (10) @(negedge clk);
        check(empty_n, 1'h1);
        run = 1'h1;
        drain();
        // double rate writes, deselected pair dropped
        restart(1'h0, 1'h1, 1'h1);
        wr(1'h1, 1'h1, 3);
        wr(1'h1, 1'h0, 1);
        wr(1'h0, 1'h1, 1);
        wr(1'h1, 1'h1, 2);
        drain();
        // fall-through with the read port deselected
        restart(1'h1, 1'h0, 1'h1);
        wr(1'h1, 1'h1, 1);
        for (k = 0; k < 8 && or_n !== 1'h0; k++) @(posedge rclk) #1;
        check(10'(k <= 5), 10'h001);
        check(oe, 1'h0);
        sel = 1'h1;
        repeat (2) @(posedge rclk);
        #3 check(oe, 1'h1);
        check(data_out, q[0]);
        rd = 1'h1;
        repeat (4) @(posedge rclk);
        check(or_n, 1'h1);
        rd = 1'h0;
        $display("test done at %0t", $time);
        end_of_test();
    end

    // watchdog well past the expected run length
    initial begin
        #500000;
        failures++;
        end_of_test();
    end
endmodule // mfpc_tb_top
`default_nettype wire
